// ===== core/tach_period_engine.sv
// Period engine: one capture on one tach input
`timescale 1ns/1ps
`default_nettype none
module tach_period_engine
    import tach_pkg::*;
#(
    parameter int EXT_CYC = EXT_CYCLES,
    parameter int NORM_CYC = NORM_SLOT_CYCLES
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Sequencer side
    tach_meas_if.engine m
);
    import tach_pkg::*;

    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_FIRST = 5'b00010,
        S_PER1 = 5'b00100,
        S_PER2 = 5'b01000,
        S_DONE = 5'b10000
    } eng_state_t;

    function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
        return (v == CNT_MAX) ? v : v + 14'h0001;
    endfunction

    function automatic logic [CNT_W-1:0] sat_dbl(input logic [CNT_W-1:0] v);
        return v[CNT_W-1] ? CNT_MAX : {v[CNT_W-2:0], 1'b0};
    endfunction

    eng_state_t state_reg;
    logic [31:0] win_reg;
    logic tach_prev_reg;
    logic [1:0] lock_reg;
    logic [CNT_W-1:0] cnt_reg;
    logic [CNT_W-1:0] mem_reg;
    logic [CNT_W-1:0] count_reg;
    logic [1:0] acc_reg;
    logic rise;
    logic fall;
    logic valid_edge;
    logic timeout;
    logic [31:0] ext_len_reg;

    assign rise = m.tach & ~tach_prev_reg;
    assign fall = ~m.tach & tach_prev_reg;
    assign timeout = (state_reg != S_IDLE) && (state_reg != S_DONE)
                     && (win_reg == 32'h0);

    // First edge of any enabled type; later only the locked type
    always_comb begin
        if (state_reg == S_FIRST) begin
            valid_edge = (rise & m.edge_sel[EDGE_RISE_BIT])
                       | (fall & m.edge_sel[EDGE_FALL_BIT]);
        end else if (lock_reg == LOCK_RISE) begin
            valid_edge = rise;
        end else begin
            valid_edge = fall & (lock_reg == LOCK_FALL);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tach_prev_reg <= 1'b0;
        end else begin
            tach_prev_reg <= m.tach;
        end
    end

    // ==========================================================
    // Window: extension in smart mode, slot limit in normal mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            win_reg <= 32'h0;
        end else if (m.start) begin
            win_reg <= m.smart ? 32'(EXT_CYC - 1) : 32'(NORM_CYC - 1);
        end else if (win_reg != 32'h0) begin
            win_reg <= win_reg - 32'h1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lock_reg <= LOCK_NONE;
        end else if (m.start) begin
            lock_reg <= LOCK_NONE;
        end else if (state_reg == S_FIRST && valid_edge) begin
            lock_reg <= rise ? LOCK_RISE : LOCK_FALL;
        end
    end

    // ==========================================================
    // Capture sequence
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_IDLE;
            cnt_reg <= '0;
            mem_reg <= '0;
            count_reg <= '0;
            acc_reg <= ACC_NORMAL;
        end else begin
            case (state_reg)
                S_IDLE, S_DONE: begin
                    if (m.start) begin
                        state_reg <= S_FIRST;
                        cnt_reg <= '0;
                    end else begin
                        state_reg <= S_IDLE;
                    end
                end
                S_FIRST: begin
                    if (timeout) begin
                        count_reg <= m.smart ? NO_PERIOD : CNT_MAX;
                        acc_reg <= m.smart ? ACC_ONE : ACC_NORMAL;
                        state_reg <= S_DONE;
                    end else if (valid_edge) begin
                        state_reg <= S_PER1;
                    end
                end
                S_PER1: begin
                    if (m.tick) begin
                        cnt_reg <= sat_inc(cnt_reg);
                    end
                    if (timeout) begin
                        count_reg <= m.smart ? NO_PERIOD : CNT_MAX;
                        acc_reg <= m.smart ? ACC_ONE : ACC_NORMAL;
                        state_reg <= S_DONE;
                    end else if (valid_edge) begin
                        mem_reg <= cnt_reg;
                        state_reg <= S_PER2;
                    end
                end
                S_PER2: begin
                    if (m.tick) begin
                        cnt_reg <= sat_inc(cnt_reg);
                    end
                    if (valid_edge) begin
                        count_reg <= cnt_reg;
                        acc_reg <= m.smart ? ACC_TWO : ACC_NORMAL;
                        state_reg <= S_DONE;
                    end else if (timeout) begin
                        count_reg <= m.smart ? sat_dbl(mem_reg) : CNT_MAX;
                        acc_reg <= m.smart ? ACC_ONE : ACC_NORMAL;
                        state_reg <= S_DONE;
                    end
                end
                default: begin
                    state_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Done pulses once, registered on the same edge that writes the result
    logic done_reg;
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            done_reg <= 1'b0;
        end else begin
            done_reg <= (state_reg != S_DONE) && (state_reg != S_IDLE)
                        && (timeout || (state_reg == S_PER2 && valid_edge));
        end
    end

    assign m.busy = (state_reg != S_IDLE) && (state_reg != S_DONE);
    assign m.extend = m.smart && m.busy;
    assign m.done = done_reg;
    assign m.count = count_reg;
    assign m.acc = acc_reg;

    // ==========================================================
    // Checks
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_len_reg <= 32'h0;
        end else begin
            ext_len_reg <= m.extend ? ext_len_reg + 32'h1 : 32'h0;
        end
    end

    property p_ext_len;
        @(posedge clk) disable iff (!rst_n) ext_len_reg <= 32'(EXT_CYC);
    endproperty
    a_ext_len: assert property (p_ext_len)
        else $error("PWM extension longer than window");

    property p_none;
        @(posedge clk) disable iff (!rst_n)
        (timeout && m.smart && state_reg == S_FIRST) |=> m.done ##0
        (m.count == NO_PERIOD) ##0 (m.acc == ACC_ONE);
    endproperty
    a_none: assert property (p_none)
        else $error("No-period result wrong");

    property p_mem;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == S_PER1 && valid_edge && !timeout) |=>
        (mem_reg == $past(cnt_reg)) ##0 (state_reg == S_PER2);
    endproperty
    a_mem: assert property (p_mem)
        else $error("Single period count not kept");

    property p_dbl;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == S_PER2 && timeout && !valid_edge && m.smart) |=>
        (m.count == sat_dbl(mem_reg)) ##0 (m.acc == ACC_ONE) ##0 m.done;
    endproperty
    a_dbl: assert property (p_dbl)
        else $error("Doubled count wrong");

    property p_two;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == S_PER2 && valid_edge && m.smart) |=>
        !m.extend ##0 m.done ##0 (m.acc == ACC_TWO);
    endproperty
    a_two: assert property (p_two)
        else $error("Two period capture did not end extension");

    property p_norm_acc;
        @(posedge clk) disable iff (!rst_n)
        (m.done && !m.smart) |-> (m.acc == ACC_NORMAL);
    endproperty
    a_norm_acc: assert property (p_norm_acc)
        else $error("Normal mode accuracy bits not zero");

    property p_lock;
        @(posedge clk) disable iff (!rst_n)
        (state_reg == S_FIRST && valid_edge && !timeout && rise) |=>
        (lock_reg == LOCK_RISE) throughout (state_reg == S_PER1) [*1];
    endproperty
    a_lock: assert property (p_lock)
        else $error("Edge type not locked to first edge");

    property p_sat;
        @(posedge clk) disable iff (!rst_n)
        (cnt_reg == CNT_MAX && state_reg == S_PER2 && !valid_edge
         && !timeout) |=> (cnt_reg == CNT_MAX);
    endproperty
    a_sat: assert property (p_sat)
        else $error("Period counter wrapped");
endmodule
`default_nettype wire

// ===== shared/tach_pkg.sv
// Constants shared by the smart fan tach measurement block
package tach_pkg;
    // ==========================================================
    // Clock and timing
    localparam int CLK_HZ = 125_000_000;
    localparam int CLK_KHZ = CLK_HZ / 1000;
    localparam int EXT_MS = 50;
    localparam int SMART_ALL_MS = 4000;
    localparam int NORM_ALL_MS = 1000;
    localparam int NUM_FANS = 4;
    // Longest time, rounded down to whole cycles
    localparam int EXT_CYCLES = EXT_MS * CLK_KHZ;
    localparam int SMART_SLOT_CYCLES = (SMART_ALL_MS / NUM_FANS) * CLK_KHZ;
    localparam int NORM_SLOT_CYCLES = (NORM_ALL_MS / NUM_FANS) * CLK_KHZ;
    // Count tick: 125 MHz / 1250 = 100 kHz
    localparam int TICK_DIV = 1250;
    localparam logic [10:0] TICK_LAST = 11'(TICK_DIV - 1);
    // ==========================================================
    // Value register layout
    localparam int CNT_W = 14;
    localparam int VAL_W = 16;
    localparam int ACC_LSB = 0;
    localparam int CNT_LSB = 2;
    localparam logic [CNT_W-1:0] CNT_MAX = 14'h3FFF;
    localparam logic [CNT_W-1:0] NO_PERIOD = 14'h03FF;
    localparam logic [1:0] ACC_NORMAL = 2'h0;
    localparam logic [1:0] ACC_TWO = 2'h3;
    localparam logic [1:0] ACC_ONE = 2'h2;
    localparam logic [VAL_W-1:0] VAL_RESET = 16'h0000;
    // Edge select field
    localparam int EDGE_RISE_BIT = 0;
    localparam int EDGE_FALL_BIT = 1;
    localparam logic [1:0] LOCK_NONE = 2'h0;
    localparam logic [1:0] LOCK_RISE = 2'h1;
    localparam logic [1:0] LOCK_FALL = 2'h2;
endpackage

// ===== shared/tach_meas_if.sv
// Carrier between the sequencer and the period engine
`timescale 1ns/1ps
`default_nettype none
interface tach_meas_if;
    logic start;
    logic smart;
    logic tick;
    logic tach;
    logic [1:0] edge_sel;
    logic busy;
    logic done;
    logic extend;
    logic [13:0] count;
    logic [1:0] acc;
    modport ctrl(output start, smart, tick, tach, edge_sel,
                 input busy, done, extend, count, acc);
    modport engine(input start, smart, tick, tach, edge_sel,
                   output busy, done, extend, count, acc);
endinterface
`default_nettype wire

// ===== core/smart_fan_tach.sv
// Smart fan tach measurement: sequencer, PWM stretch, value store
`timescale 1ns/1ps
`default_nettype none
module smart_fan_tach
    import tach_pkg::*;
#(
    parameter int EXT_CYC = tach_pkg::EXT_CYCLES,
    parameter int SMART_SLOT = tach_pkg::SMART_SLOT_CYCLES,
    parameter int NORM_SLOT = tach_pkg::NORM_SLOT_CYCLES
) (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // Mode
    input wire logic smart_mode_in,
    input wire logic [1:0] tach_edge_in,
    // Fan signals
    input wire logic [3:0] tach_in,
    input wire logic [1:0] pwm_in,
    output logic [1:0] pwm_out,
    // Results
    input wire logic [4*tach_pkg::VAL_W-1:0] limit_in,
    output logic [4*tach_pkg::VAL_W-1:0] value_out,
    output logic [3:0] tach_err_out,
    output logic [3:0] value_upd_out
);
    import tach_pkg::*;

    tach_meas_if m ();

    logic [1:0] rst_sync_reg;
    logic rst_n;
    logic [10:0] div_reg;
    logic tick;
    logic [31:0] slot_reg;
    logic [1:0] ch_reg;
    logic start_reg;
    logic [VAL_W-1:0] value_reg [NUM_FANS];
    logic [3:0] err_reg;
    logic [3:0] upd_reg;
    logic [1:0] pwm_reg;
    logic [VAL_W-1:0] new_val;

    // ==========================================================
    // Reset release
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_sync_reg <= 2'b00;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ==========================================================
    // Count tick divider
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            div_reg <= 11'h000;
        end else begin
            div_reg <= (div_reg == TICK_LAST) ? 11'h000 : div_reg + 11'h001;
        end
    end
    assign tick = (div_reg == TICK_LAST);

    // ==========================================================
    // Slot sequencer: one fan per slot, round robin
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            slot_reg <= 32'h0;
            // First slot start wraps this to fan 0
            ch_reg <= 2'h3;
            start_reg <= 1'b0;
        end else begin
            start_reg <= 1'b0;
            if (slot_reg == 32'h0) begin
                // Four slots of 1 s in smart mode, 250 ms in normal mode
                slot_reg <= smart_mode_in ? 32'(SMART_SLOT - 1)
                                          : 32'(NORM_SLOT - 1);
                start_reg <= 1'b1;
                // Fan moves with the slot start, so a result that lands
                // on the last slot cycle is still stored for its own fan
                ch_reg <= ch_reg + 2'h1;
            end else begin
                slot_reg <= slot_reg - 32'h1;
            end
        end
    end

    assign m.start = start_reg;
    assign m.smart = smart_mode_in;
    assign m.tick = tick;
    assign m.tach = tach_in[ch_reg];
    assign m.edge_sel = smart_mode_in ? tach_edge_in : 2'b11;

    tach_period_engine #(
        .EXT_CYC(EXT_CYC),
        .NORM_CYC(NORM_SLOT - 2)
    ) u_engine (
        .clk(core_clk_in),
        .rst_n(rst_n),
        .m(m)
    );

    // ==========================================================
    // PWM: both forced active together for a smart mode capture
    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            pwm_reg <= 2'b00;
        end else begin
            pwm_reg <= m.extend ? 2'b11 : pwm_in;
        end
    end
    assign pwm_out = pwm_reg;

    // ==========================================================
    // Value store and limit compare
    assign new_val = {m.count, (m.smart ? m.acc : ACC_NORMAL)};

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < NUM_FANS; i++) begin
                value_reg[i] <= VAL_RESET;
            end
        end else if (m.done) begin
            value_reg[ch_reg] <= new_val;
        end
    end

    always_ff @(posedge core_clk_in or negedge rst_n) begin
        if (!rst_n) begin
            err_reg <= 4'h0;
            upd_reg <= 4'h0;
        end else begin
            upd_reg <= 4'h0;
            if (m.done) begin
                upd_reg[ch_reg] <= 1'b1;
                // Period above limit means a slow fan
                err_reg[ch_reg] <= new_val[VAL_W-1:CNT_LSB] >
                    limit_in[ch_reg*VAL_W+CNT_LSB +: CNT_W];
            end
        end
    end

    always_comb begin
        for (int i = 0; i < NUM_FANS; i++) begin
            value_out[i*VAL_W +: VAL_W] = value_reg[i];
        end
    end
    assign tach_err_out = err_reg;
    assign value_upd_out = upd_reg;

    // ==========================================================
    // Checks
    property p_align;
        @(posedge core_clk_in) disable iff (!rst_n)
        $rose(m.extend) |=> (pwm_out == 2'b11) [*2];
    endproperty
    a_align: assert property (p_align)
        else $error("PWM outputs not aligned at capture start");

    property p_err;
        @(posedge core_clk_in) disable iff (!rst_n)
        m.done |=> (tach_err_out[$past(ch_reg)] ==
            ($past(m.count) > $past(limit_in[ch_reg*VAL_W+CNT_LSB +: CNT_W])));
    endproperty
    a_err: assert property (p_err)
        else $error("Tach error flag does not match limit");

    property p_store;
        @(posedge core_clk_in) disable iff (!rst_n)
        (m.done && !smart_mode_in) |=>
        (value_reg[$past(ch_reg)][1:0] == ACC_NORMAL);
    endproperty
    a_store: assert property (p_store)
        else $error("Stored normal value has nonzero low bits");

    property p_start_slot;
        @(posedge core_clk_in) disable iff (!rst_n)
        start_reg |=> m.busy;
    endproperty
    a_start_slot: assert property (p_start_slot)
        else $error("Capture did not start in its slot");
endmodule
`default_nettype wire

// ===== dv/fan_tach_model.sv
// Behavioural fan: tach output that is held, free-running or a short burst
`timescale 1ns/1ps
`default_nettype none
module fan_tach_model (
    // Clock
    input wire logic clk_in,
    // Behaviour: 0 held at level, 1 square wave, 2 burst after drive rises
    input wire logic [1:0] kind_in,
    input wire logic [15:0] period_in,
    input wire logic level_in,
    // Fan drive and tach
    input wire logic drive_in,
    output logic tach_out
);
    int cnt;
    logic drive_q;

    initial begin
        cnt = 4000;
        drive_q = 1'b0;
        tach_out = 1'b0;
    end

    // ==========================================================
    // Tach generation
    always @(posedge clk_in) begin
        drive_q <= drive_in;
        if (kind_in == 2'h1) begin
            cnt <= (cnt + 1 >= period_in / 2) ? 0 : cnt + 1;
            if (cnt + 1 >= period_in / 2) begin
                tach_out <= ~tach_out;
            end
        end else if (kind_in == 2'h2) begin
            // Burst restarts with every rise of the fan drive
            if (drive_in && !drive_q) begin
                cnt <= 0;
            end else if (cnt < 4000) begin
                cnt <= cnt + 1;
            end
            if (cnt == 100 || cnt == 200 || cnt == 1500 || cnt == 1600 ||
                cnt == 2900) begin
                tach_out <= ~tach_out;
            end
        end else begin
            cnt <= 4000;
            tach_out <= level_in;
        end
    end
endmodule
`default_nettype wire

// ===== dv/smart_fan_tach_tb.sv
// Self-checking testbench of the smart fan tach measurement block
`timescale 1ns/1ps
`default_nettype none
module smart_fan_tach_tb;
    import tach_pkg::*;

    localparam int EXT = 5000;
    localparam int SLOT = 5100;
    localparam int CYC_LIMIT = 90000;

    logic core_clk_in = 1'b0;
    logic nrst_in = 1'b0;
    logic smart_mode_in = 1'b1;
    logic [1:0] tach_edge_in = 2'h3;
    logic [3:0] tach_in;
    logic [1:0] pwm_in = 2'h0;
    logic [1:0] pwm_out;
    logic [63:0] limit_in = 64'h0FFC_0FF8_FFFF_0004;
    logic [63:0] value_out;
    logic [3:0] tach_err_out;
    logic [3:0] value_upd_out;
    logic [1:0] kind [4] = '{2'h0, 2'h0, 2'h0, 2'h0};
    logic [15:0] per [4] = '{16'h04E2, 16'h0BB8, 16'h04E2, 16'h05DC};
    logic lvl = 1'b0;
    logic pwm_run = 1'b0;
    logic [1:0] pwm_q = 2'h0;
    int n_errors = 0;
    int samples_checked = 0;
    int cyc = 0;
    int alive = 0;
    int run = 0;
    int max_run = 0;
    int t0 = 0;

    always #4 core_clk_in = ~core_clk_in;

    smart_fan_tach #(.EXT_CYC(EXT), .SMART_SLOT(SLOT), .NORM_SLOT(SLOT))
    u_smart_fan_tach (
        .core_clk_in(core_clk_in), .nrst_in(nrst_in),
        .smart_mode_in(smart_mode_in), .tach_edge_in(tach_edge_in),
        .tach_in(tach_in), .pwm_in(pwm_in), .pwm_out(pwm_out),
        .limit_in(limit_in), .value_out(value_out),
        .tach_err_out(tach_err_out), .value_upd_out(value_upd_out)
    );

    for (genvar g = 0; g < 4; g++) begin : g_fan
        fan_tach_model u_fan_tach_model (
            .clk_in(core_clk_in), .kind_in(kind[g]), .period_in(per[g]),
            .level_in(lvl), .drive_in(pwm_out[0]), .tach_out(tach_in[g])
        );
    end

    // ==========================================================
    // Reporting
    task automatic give_verdict();
        $display("errors %0d checks %0d", n_errors, samples_checked);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic check_rng(input logic [31:0] got, input logic [31:0] lo,
                             input logic [31:0] hi);
        samples_checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, lo);
        end
    endtask

    // ==========================================================
    // Monitor: pwm pass-through, stretch length, alignment, timeout
    always @(posedge core_clk_in) begin
        cyc++;
        alive = nrst_in ? alive + 1 : 0;
        if (alive > 4 && !smart_mode_in) begin
            check({30'h0, pwm_out}, {30'h0, pwm_q});
        end
        if (alive > 4 && smart_mode_in && pwm_in == 2'h0) begin
            run = (pwm_out == 2'h3) ? run + 1 : 0;
            if (run > max_run) begin
                max_run = run;
            end
            if (pwm_out == 2'h1 || pwm_out == 2'h2) begin
                check({30'h0, pwm_out}, 32'h3);
            end
        end
        pwm_q = pwm_in;
        if (cyc >= CYC_LIMIT) begin
            n_errors++;
            give_verdict();
        end
    end

    always @(posedge core_clk_in) begin
        #1;
        if (pwm_run) begin
            pwm_in = pwm_in + 2'h1;
        end
    end

    // ==========================================================
    // Shared steps
    task automatic do_reset(input logic smart, input logic [1:0] sel,
                            input logic level);
        @(posedge core_clk_in);
        #1;
        nrst_in = 1'b0;
        smart_mode_in = smart;
        tach_edge_in = sel;
        lvl = level;
        pwm_run = 1'b0;
        pwm_in = 2'h0;
        for (int f = 0; f < 4; f++) kind[f] = 2'h0;
        repeat (2) @(posedge core_clk_in);
        #1;
        nrst_in = 1'b1;
        t0 = cyc;
    endtask

    task automatic wait_upd(input int i, output logic [15:0] v);
        int n;
        n = 0;
        while (value_upd_out[i] !== 1'b1 && n < 20000) begin
            @(posedge core_clk_in);
            #1;
            n++;
        end
        check({31'h0, n < 20000}, 32'h1);
        v = value_out[16*i +: 16];
        check({31'h0, tach_err_out[i]},
              {31'h0, v[15:2] > limit_in[16*i+2 +: 14]});
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_smart_basic();
        logic [15:0] v;
        do_reset(1'b1, 2'h3, 1'b0);
        kind = '{2'h1, 2'h1, 2'h0, 2'h1};
        max_run = 0;
        wait_upd(0, v);
        check({30'h0, v[1:0]}, {30'h0, ACC_TWO});
        check_rng({18'h0, v[15:2]}, 32'h1, 32'h3);
        check({30'h0, pwm_out}, 32'h0);
        check_rng(cyc - t0, 32'h0, 32'hFA0);
        wait_upd(1, v);
        check({30'h0, v[1:0]}, {30'h0, ACC_ONE});
        check({31'h0, v[2]}, 32'h0);
        check_rng({18'h0, v[15:2]}, 32'h4, 32'h6);
        wait_upd(2, v);
        check({16'h0, v}, 32'h0FFE);
        check({30'h0, v[1:0]}, {30'h0, ACC_ONE});
        wait_upd(3, v);
        check_rng({18'h0, v[15:2]}, 32'h1, 32'h3);
        check_rng(cyc - t0, 32'h0, 4 * SLOT + 10);
        check_rng(max_run, EXT - 3, EXT + 2);
    endtask

    task automatic t_edges();
        logic [15:0] v;
        logic [1:0] exp;
        for (int s = 1; s < 4; s++) begin
            for (int l = 0; l < 2; l++) begin
                do_reset(1'b1, 2'(s), 1'(l));
                kind[0] = 2'h2;
                exp = (s == 3 || (s == 1) == (l == 0)) ? ACC_TWO : ACC_ONE;
                wait_upd(0, v);
                if (s == 3) begin
                    check({30'h0, v[1:0]}, {30'h0, exp});
                end else begin
                    check({30'h0, v[1:0]}, {30'h0, exp});
                end
            end
        end
    endtask

    task automatic t_normal();
        logic [15:0] v;
        do_reset(1'b0, 2'h3, 1'b0);
        kind = '{2'h1, 2'h0, 2'h1, 2'h1};
        pwm_run = 1'b1;
        wait_upd(0, v);
        check({30'h0, v[1:0]}, {30'h0, ACC_NORMAL});
        check_rng({18'h0, v[15:2]}, 32'h1, 32'h3);
        wait_upd(1, v);
        check({16'h0, v}, 32'hFFFC);
        wait_upd(2, v);
        check({30'h0, v[1:0]}, {30'h0, ACC_NORMAL});
        wait_upd(3, v);
        check_rng(cyc - t0, 32'h0, 4 * SLOT + 10);
        pwm_run = 1'b0;
    endtask

    initial begin
        repeat (2) @(posedge core_clk_in);
        t_smart_basic();
        t_edges();
        t_normal();
        give_verdict();
    end
endmodule
`default_nettype wire
